// file: design/bdwc_pkg.sv
/*
 Constants, enumerations and carrier structs for the transmit demo controller.
 Assumes a single 25 MHz system clock that also serves as the drive timebase.
*/
package bdwc_pkg;
	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_HZ = 25_000_000;
	localparam int DEBOUNCE_US = 10000; // Contact bounce settles well inside this
	localparam int DEBOUNCE_CYC = CLK_HZ / 1_000_000 * DEBOUNCE_US;
	localparam int REPEAT_US = 50; // Free-running burst period without trigger
	localparam int REPEAT_CYC = CLK_HZ / 1_000_000 * REPEAT_US;
	localparam int SCK_HALF_CYC = 2; // Serial clock half period
	localparam int BURST_CYCLES = 8; // Output cycles per burst
	// ----------------------------------------------------------------
	// Selections
	// ----------------------------------------------------------------
	localparam int PHASE_STEPS = 48;
	localparam logic [5:0] PHASE_LAST = 6'h2f;
	localparam logic [5:0] PHASE_RESET = 6'h00;
	localparam logic [4:0] LEVEL_LAST = 5'h10;
	localparam logic [4:0] LEVEL_RESET = 5'h08;
	localparam logic [4:0] LEVEL_MID = 5'h08;
	localparam logic [7:0] LEVEL_FULL = 8'hff;
	localparam logic [4:0] SPC_12 = 5'h0c;
	localparam logic [4:0] SPC_16 = 5'h10;
	localparam logic [4:0] SPC_20 = 5'h14;
	localparam logic [4:0] FRAME_LAST = 5'h0f; // 16-bit frame: level code, 2 pad, phase
	// Button vector positions
	localparam int BTN_ON = 0;
	localparam int BTN_RATE = 1;
	localparam int BTN_PHASE = 2;
	localparam int BTN_LEVEL = 3;
	localparam int BTN_RUN = 4;
	localparam int BTN_COUNT = 5;
	typedef enum logic [1:0] {RATE_13M3 = 2'b00, RATE_10M0 = 2'b01, RATE_8M0 = 2'b10} bdwc_rate_type;
	localparam bdwc_rate_type RATE_RESET = RATE_10M0;
	typedef enum logic [1:0] {SER_IDLE = 2'b00, SER_SHIFT = 2'b01, SER_LOAD = 2'b10} bdwc_ser_type;
	typedef struct packed {
		logic inphase_drive_a;
		logic inphase_drive_b;
		logic quadrature_drive_a;
		logic quadrature_drive_b;
	} bdwc_drive_type;
	typedef struct packed {
		logic data;
		logic clock;
		logic select_n;
		logic load;
	} bdwc_serial_type;
endpackage

// file: design/bdwc_top.sv
/*
 Button-driven waveform controller for an ultrasound push-pull driver chip:
 debounced buttons, frequency/phase/level selection, I/Q drive bursts and a
 serial register loader. Assumes all inputs are synchronous to sys_clk and
 that the driver chip samples serial data on the rising serial clock.
*/
`timescale 1ns/100ps
// Overview of operation
// RULE1: Timebase samples per output cycle are 12, 16 or 20 by rate selection.
// RULE2: Phase index covers 48 steps of 7.5 degrees per cycle.
// RULE3: Phase index N means N times 7.5 degrees; 48 wraps to zero.
// RULE4: Reset sets phase index zero and lights the zero-angle lamp.
// RULE5: Level index N gives code 16N; index 16 gives 255.
// RULE6: Reset sets level index 8, code 128, and lights the mid-level lamp.
// RULE7: The level is sent to the driver as an 8-bit code.
// RULE8: Four drive lines, two in-phase and two quadrature, form each burst.
// RULE9: Serial data and clock load the driver level and phase registers.
// RULE10: In sync mode each burst launches on a rising trigger edge.
// RULE11: Five buttons: enable, rate, phase step, level step, run.
// RULE12: Zero-angle lamp is lit exactly while phase index is zero. The lamp follows the index one cycle later.
// RULE13: Enable button toggles the driver's active-high enable line.
// RULE14: Each debounced press advances one step, wrapping after the last.
// RULE15: A changed phase or level is reloaded before the next burst launch.
module bdwc_top #(
	parameter int DEBOUNCE_CYCLES = bdwc_pkg::DEBOUNCE_CYC, // Button settle time
	parameter int REPEAT_CYCLES = bdwc_pkg::REPEAT_CYC // Untriggered burst period
) (
	input wire logic sys_clk, // 25 MHz clock
	input wire logic srst, // Synchronous reset, active high
	input wire logic output_on_button, // Enable button, high while pressed
	input wire logic rate_select_button, // Frequency button
	input wire logic phase_step_button, // Phase step button
	input wire logic level_step_button, // Amplitude step button
	input wire logic run_button, // Run/stop button
	input wire logic burst_sync_in, // External trigger
	input wire logic sync_mode, // 1: bursts follow trigger
	output bdwc_pkg::bdwc_drive_type drive, // I/Q drive lines
	output bdwc_pkg::bdwc_serial_type serial, // Serial register link
	output logic driver_enable, // Driver enable, active high
	output logic zero_angle_lamp, // Phase is zero
	output logic midlevel_lamp, // Level index is mid-scale
	output logic running, // Bursts allowed
	output bdwc_pkg::bdwc_rate_type rate_sel // Selected frequency
);
	import bdwc_pkg::*;

	localparam int DBW = $clog2(DEBOUNCE_CYCLES + 1);
	localparam int RPW = $clog2(REPEAT_CYCLES + 1);

	// ----------------------------------------------------------------
	// Parameter checks
	// ----------------------------------------------------------------
	if (DEBOUNCE_CYCLES < 2 || REPEAT_CYCLES < 2) begin : g_bad_param
		$error("bdwc_top: counts must be at least 2");
	end

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (srst);

	// Level index to 8-bit driver code
	function automatic logic [7:0] level_code(input logic [4:0] idx);
		return (idx == LEVEL_LAST) ? LEVEL_FULL : {idx[3:0], 4'h0}; // [RULE5] [RULE7]
	endfunction

	// Samples per output cycle for a rate
	function automatic logic [4:0] rate_spc(input bdwc_rate_type r);
		case (r) // [RULE1]
			RATE_13M3: return SPC_12;
			RATE_8M0: return SPC_20;
			default: return SPC_16;
		endcase
	endfunction

	// ----------------------------------------------------------------
	// Button debounce
	// ----------------------------------------------------------------
	logic [BTN_COUNT-1:0] btn_raw;
	logic [BTN_COUNT-1:0] btn_state;
	logic [BTN_COUNT-1:0] btn_press;
	assign btn_raw = {run_button, level_step_button, phase_step_button, rate_select_button,
		output_on_button}; // [RULE11]

	// A level must hold for the full settle time; only the press edge counts
	for (genvar g = 0; g < BTN_COUNT; g++) begin : g_btn
		logic [DBW-1:0] cnt;
		always_ff @(posedge sys_clk) begin
			if (srst) begin
				cnt <= '0;
				btn_state[g] <= 1'b0;
				btn_press[g] <= 1'b0;
			end else begin
				btn_press[g] <= 1'b0;
				if (btn_raw[g] == btn_state[g]) begin
					cnt <= '0;
				end else if (cnt == DBW'(DEBOUNCE_CYCLES - 1)) begin
					cnt <= '0;
					btn_state[g] <= btn_raw[g];
					btn_press[g] <= btn_raw[g]; // [RULE14]
				end else begin
					cnt <= cnt + 1'b1;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Selections
	// ----------------------------------------------------------------
	logic [5:0] phase_idx;
	logic [4:0] level_idx;

	// Each press moves one step and wraps
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			phase_idx <= PHASE_RESET; // [RULE4]
			level_idx <= LEVEL_RESET; // [RULE6]
			rate_sel <= RATE_RESET;
			driver_enable <= 1'b0;
			running <= 1'b1;
		end else begin
			if (btn_press[BTN_PHASE]) begin
				phase_idx <= (phase_idx == PHASE_LAST) ? 6'h00 : phase_idx + 6'h01; // [RULE2] [RULE3] [RULE14]
			end
			if (btn_press[BTN_LEVEL]) begin
				level_idx <= (level_idx == LEVEL_LAST) ? 5'h00 : level_idx + 5'h01; // [RULE14]
			end
			if (btn_press[BTN_RATE]) begin
				rate_sel <= (rate_sel == RATE_8M0) ? RATE_13M3 : rate_sel.next(); // [RULE14]
			end
			if (btn_press[BTN_ON]) begin
				driver_enable <= ~driver_enable; // [RULE13]
			end
			if (btn_press[BTN_RUN]) begin
				running <= ~running;
			end
		end
	end

	// Indicator lamps follow the selections one cycle later
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			zero_angle_lamp <= 1'b1; // [RULE4]
			midlevel_lamp <= 1'b1; // [RULE6]
		end else begin
			zero_angle_lamp <= (phase_idx == 6'h00); // [RULE12]
			midlevel_lamp <= (level_idx == LEVEL_MID);
		end
	end

	// ----------------------------------------------------------------
	// Serial register loader
	// ----------------------------------------------------------------
	bdwc_ser_type ser_state;
	logic reload_pend;
	logic [15:0] shreg;
	logic [4:0] bit_cnt;
	logic [1:0] sck_div;
	logic sck_tick;
	logic bursting;
	logic frame_go;
	logic [7:0] level_now;

	assign sck_tick = (sck_div == 2'(SCK_HALF_CYC - 1));
	assign frame_go = (ser_state == SER_IDLE) && reload_pend && !bursting;
	assign level_now = level_code(level_idx); // [RULE5] [RULE7]

	// Half-period enable for the serial clock
	always_ff @(posedge sys_clk) begin
		if (srst || ser_state == SER_IDLE) begin
			sck_div <= 2'h0;
		end else begin
			sck_div <= sck_tick ? 2'h0 : sck_div + 2'h1;
		end
	end

	// Pending flag: reset loads the defaults; a new press beats the clear
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			reload_pend <= 1'b1;
		end else if (btn_press[BTN_PHASE] || btn_press[BTN_LEVEL]) begin
			reload_pend <= 1'b1; // [RULE15]
		end else if (frame_go) begin
			reload_pend <= 1'b0;
		end
	end

	// Frame: MSB first, data changes with the falling serial clock
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			ser_state <= SER_IDLE;
			serial <= '{data: 1'b0, clock: 1'b0, select_n: 1'b1, load: 1'b0};
			shreg <= 16'h0000;
			bit_cnt <= 5'h00;
		end else begin
			case (ser_state)
				SER_IDLE: begin
					if (frame_go) begin
						shreg <= {level_now, 2'b00, phase_idx}; // [RULE7] [RULE9]
						serial.data <= level_now[7];
						serial.select_n <= 1'b0;
						bit_cnt <= 5'h00;
						ser_state <= SER_SHIFT;
					end
				end
				SER_SHIFT: begin
					if (sck_tick && !serial.clock) begin
						serial.clock <= 1'b1;
					end else if (sck_tick) begin
						serial.clock <= 1'b0;
						if (bit_cnt == FRAME_LAST) begin
							serial.select_n <= 1'b1;
							serial.load <= 1'b1; // [RULE9]
							ser_state <= SER_LOAD;
						end else begin
							bit_cnt <= bit_cnt + 5'h01;
							serial.data <= shreg[14];
							shreg <= {shreg[14:0], 1'b0};
						end
					end
				end
				SER_LOAD: begin
					if (sck_tick) begin
						serial.load <= 1'b0;
						serial.data <= 1'b0;
						ser_state <= SER_IDLE;
					end
				end
				default: ser_state <= SER_IDLE;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Burst timing and I/Q drive
	// ----------------------------------------------------------------
	logic trig_q;
	logic [RPW-1:0] rep_cnt;
	logic launch;
	logic [4:0] spc;
	logic [4:0] samp;
	logic [3:0] cyc;
	logic [4:0] half;
	logic [4:0] quarter;

	// Launch only with the driver registers current
	assign launch = driver_enable && running && !bursting && !reload_pend && ser_state == SER_IDLE
		&& (sync_mode ? (burst_sync_in && !trig_q) : (rep_cnt == '0)); // [RULE10] [RULE15]
	assign half = {1'b0, spc[4:1]};
	assign quarter = {2'b00, spc[4:2]};

	// Trigger edge memory and free-running repeat timer
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			trig_q <= 1'b0;
			rep_cnt <= '0;
		end else begin
			trig_q <= burst_sync_in;
			rep_cnt <= (rep_cnt == '0) ? RPW'(REPEAT_CYCLES - 1) : rep_cnt - 1'b1;
		end
	end

	// Rate is latched at launch so a press never cuts a cycle short
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			bursting <= 1'b0;
			spc <= SPC_16;
			samp <= 5'h00;
			cyc <= 4'h0;
		end else if (launch) begin
			bursting <= 1'b1;
			spc <= rate_spc(rate_sel); // [RULE1]
			samp <= 5'h00;
			cyc <= 4'h0;
		end else if (bursting) begin
			if (samp == spc - 5'h01) begin
				samp <= 5'h00;
				cyc <= cyc + 4'h1;
				bursting <= (cyc != 4'(BURST_CYCLES - 1));
			end else begin
				samp <= samp + 5'h01;
			end
		end
	end

	// In-phase pair splits the cycle in halves; quadrature lags by a quarter
	always_ff @(posedge sys_clk) begin
		if (srst || !bursting) begin
			drive <= '0;
		end else begin
			drive.inphase_drive_a <= (samp < half); // [RULE8]
			drive.inphase_drive_b <= (samp >= half);
			drive.quadrature_drive_a <= (samp >= quarter) && (samp < quarter + half);
			drive.quadrature_drive_b <= !((samp >= quarter) && (samp < quarter + half));
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	sequence s_frame_go;
		frame_go;
	endsequence
	sequence s_frame_done;
		##[60:100] serial.load;
	endsequence

	a_reset_dflt: assert property ($fell(srst) |-> phase_idx == PHASE_RESET && level_idx == LEVEL_RESET) // [RULE4] [RULE6]
		else $error("Reset defaults wrong");
	a_phase_wrap: assert property (btn_press[BTN_PHASE] && phase_idx == PHASE_LAST |=> phase_idx == 6'h00) // [RULE3]
		else $error("Phase did not wrap");
	a_level_wrap: assert property (btn_press[BTN_LEVEL] && level_idx == LEVEL_LAST |=> level_idx == 5'h00) // [RULE14]
		else $error("Level did not wrap");
	a_zero_lamp: assert property (##1 zero_angle_lamp == ($past(phase_idx) == 6'h00)) // [RULE12]
		else $error("Zero lamp mismatch");
	a_enable_toggle: assert property (btn_press[BTN_ON] |=> driver_enable != $past(driver_enable)) // [RULE13]
		else $error("Enable did not toggle");
	a_frame_load: assert property (s_frame_go |-> s_frame_done) // [RULE9]
		else $error("Serial frame did not finish");
	a_launch_fresh: assert property (launch |-> !reload_pend && serial.select_n) // [RULE15]
		else $error("Launch with stale registers");
	a_sample_range: assert property (bursting |-> samp < spc && (spc == SPC_12 || spc == SPC_16 || spc == SPC_20)) // [RULE1]
		else $error("Sample count out of range");
	a_drive_pair: assert property (##1 $past(bursting) |-> drive.inphase_drive_a != drive.inphase_drive_b) // [RULE8]
		else $error("In-phase pair overlap");
	a_trig_launch: assert property (launch && sync_mode |-> burst_sync_in && !trig_q) // [RULE10]
		else $error("Launch without trigger");
endmodule // bdwc_top

// file: testbench/bdwc_driver_model.sv
/*
 Behavioural model of the driver chip's serial register port.
 Assumes data is taken on the rising serial clock while selected.
*/
`timescale 1ns/100ps
module bdwc_driver_model (
	input wire bdwc_pkg::bdwc_serial_type serial, // Link from controller
	output logic [7:0] level_code, // Latched amplitude code
	output logic [5:0] phase_code, // Latched phase index
	output int loads // Latched frame count
);
	import bdwc_pkg::*;
	logic [15:0] shift;
	// ----------------------------------------------------------------
	// Register port
	// ----------------------------------------------------------------
	// Power-on contents of the chip's registers
	initial begin
		shift = 16'h0000;
		level_code = 8'h00;
		phase_code = 6'h00;
		loads = 0;
	end
	// Shift in MSB first; ignored while deselected so stray clocks do no harm
	always @(posedge serial.clock) begin
		if (!serial.select_n) begin
			shift <= {shift[14:0], serial.data};
		end
	end
	// Load moves the frame into the level and phase registers
	always @(posedge serial.load) begin
		level_code <= shift[15:8];
		phase_code <= shift[5:0];
		loads <= loads + 1;
	end
endmodule // bdwc_driver_model

// file: testbench/test_bdwc_top.sv
/*
 Self-checking bench for the waveform controller.
 Assumes the driver chip model on the serial link and short settle counts.
*/
`timescale 1ns/100ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin fails++; $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); end end
module test_bdwc_top;
	import bdwc_pkg::*;
	localparam int DEB = 4;
	logic sys_clk = 1'b0;
	logic srst = 1'b1;
	logic [4:0] btn = 5'h00;
	logic trig = 1'b0;
	logic sync_mode = 1'b0;
	bdwc_drive_type drive;
	bdwc_serial_type serial;
	logic driver_enable, zero_angle_lamp, midlevel_lamp, running;
	bdwc_rate_type rate_sel;
	logic [7:0] level_code;
	logic [5:0] phase_code;
	int loads;
	int fails = 0;
	int comparisons = 0;
	int sp[3] = '{20, 12, 16};
	bdwc_rate_type rt[3] = '{RATE_8M0, RATE_13M3, RATE_10M0};
	// ----------------------------------------------------------------
	// Clock, design and model
	// ----------------------------------------------------------------
	always #20 sys_clk = ~sys_clk;
	bdwc_top #(.DEBOUNCE_CYCLES(DEB), .REPEAT_CYCLES(50)) u_bdwc_top (.sys_clk(sys_clk), .srst(srst),
		.output_on_button(btn[BTN_ON]), .rate_select_button(btn[BTN_RATE]), .phase_step_button(btn[BTN_PHASE]),
		.level_step_button(btn[BTN_LEVEL]), .run_button(btn[BTN_RUN]), .burst_sync_in(trig),
		.sync_mode(sync_mode), .drive(drive), .serial(serial), .driver_enable(driver_enable),
		.zero_angle_lamp(zero_angle_lamp), .midlevel_lamp(midlevel_lamp), .running(running),
		.rate_sel(rate_sel));
	bdwc_driver_model u_bdwc_driver_model (.serial(serial), .level_code(level_code), .phase_code(phase_code),
		.loads(loads));
	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	// Inputs always move 1 ns after the edge so sampling never races
	task automatic tick;
		@(posedge sys_clk);
		#1;
	endtask
	// Hold past the settle time both ways, else the release eats the next press
	task automatic press(input int b);
		btn[b] = 1'b1;
		repeat (DEB + 3) tick();
		btn[b] = 1'b0;
		repeat (DEB + 3) tick();
	endtask
	// Bounded wait for the model to latch a frame after count n
	task automatic wait_frame(input int n);
		int k;
		k = 0;
		while (loads == n && k < 400) begin
			tick();
			k++;
		end
		`CHK(loads != n, 1'b1)
		tick();
	endtask
	task automatic press_frame(input int b);
		int n;
		n = loads;
		press(b);
		wait_frame(n);
	endtask
	// A gap between bursts is the only time all four lines are low
	task automatic idle_wait;
		int k;
		k = 0;
		while (drive !== 4'h0 && k < 400) begin
			tick();
			k++;
		end
	endtask
	// Times the in-phase high half and the quadrature offset of one cycle
	task automatic measure(input int spc);
		int k, qd;
		idle_wait();
		k = 0;
		while (drive.inphase_drive_a !== 1'b1 && k < 400) begin
			tick();
			k++;
		end
		k = 0;
		qd = -1;
		while (drive.inphase_drive_a === 1'b1 && k < 40) begin
			if (drive.quadrature_drive_a === 1'b1 && qd < 0) qd = k;
			tick();
			k++;
		end
		`CHK(k, spc / 2)
		`CHK(qd, spc / 4)
	endtask
	task automatic conclude;
		$display("comparisons=%0d fails=%0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	// ----------------------------------------------------------------
	// Tests
	// ----------------------------------------------------------------
	// Watchdog well beyond the expected run of about 6000 cycles
	initial begin
		#1200000;
		fails++;
		conclude();
	end
	initial begin
		int v;
		int quiet;
		repeat (10) tick();
		srst = 1'b0;
		tick();
		`CHK(driver_enable, 1'b0)
		`CHK(zero_angle_lamp, 1'b1)
		`CHK(midlevel_lamp, 1'b1)
		`CHK(rate_sel, RATE_10M0)
		wait_frame(0);
		`CHK(level_code, 8'h80)
		`CHK(phase_code, 6'h00)
		$display("test reset done");
		for (int i = 1; i <= 17; i++) begin
			v = (8 + i) % 17;
			press_frame(BTN_LEVEL);
			`CHK(level_code, (v == 16) ? 8'hff : 8'(v * 16))
			`CHK(midlevel_lamp, v == 8)
		end
		$display("test level done");
		for (int i = 1; i <= 48; i++) begin
			v = i % 48;
			press_frame(BTN_PHASE);
			`CHK(phase_code, 6'(v))
			`CHK(zero_angle_lamp, v == 0)
		end
		`CHK(drive, 4'h0)
		$display("test phase done");
		press(BTN_ON);
		`CHK(driver_enable, 1'b1)
		measure(16);
		for (int i = 0; i < 3; i++) begin
			press(BTN_RATE);
			`CHK(rate_sel, rt[i])
			measure(sp[i]);
		end
		$display("test rate done");
		sync_mode = 1'b1;
		// A free-running launch on the edge just passed shows on drive only one edge later
		tick();
		idle_wait();
		quiet = 1;
		repeat (100) begin
			tick();
			if (drive !== 4'h0) quiet = 0;
		end
		`CHK(quiet, 1)
		trig = 1'b1;
		repeat (3) tick();
		`CHK(drive.inphase_drive_a, 1'b1)
		trig = 1'b0;
		$display("test trigger done");
		press(BTN_RUN);
		`CHK(running, 1'b0)
		idle_wait();
		trig = 1'b1;
		quiet = 1;
		repeat (20) begin
			tick();
			if (drive !== 4'h0) quiet = 0;
		end
		`CHK(quiet, 1)
		$display("test run done");
		conclude();
	end
endmodule // test_bdwc_top
